// [tmpll_defs.svh]
// Register offsets, field positions, reset values and operation summary of the micro tick PLL
// Summary of operation
// - Emit ticks_per_event_m1 plus one ticks per event
// - Nominal tooth count sets events per half scale
// - Virtual tooth count gives missing teeth per half scale
// - Two-bit field selects active trigger edge
// - Tick mode bit zero selects automatic end
// - Enable bit starts the PLL; ticks follow the second active slope
// - Missing ticks replayed at fast clock rate
// - Plausibility window unit: time or position
// - Tick output bit gates both tick lines
// - Direct load: software sets tick rate
// - Pulse correction off keeps catch-up ticks off the raw line only
// - Adaptation off uses nominal profile entry
// - Tick source bit zero selects trigger input
// - Slope timeout raises timeout events after start
// - Minimum time to inactive slope, stamp ticks
// - Profile store cleared after reset, busy flag
// - Profile entry holds increments and interrupt request
// - Interrupt enable bit 18 gates profile interrupt
// - Protected control fields ignore writes while enabled
// - Pointer write while enabled sets locked flag
// - Ticks drive second time-base channel
`ifndef TMPLL_DEFS_SVH
`define TMPLL_DEFS_SVH

// Register port geometry
`define TMPLL_ADDR_W 12
`define TMPLL_DATA_W 32

// Register offsets
`define TMPLL_OFS_CTRL0 12'h000
`define TMPLL_OFS_CTRL1 12'h004
`define TMPLL_OFS_PTR 12'h008
`define TMPLL_OFS_MIN_INACT 12'h00C
`define TMPLL_OFS_TIMEOUT 12'h010
`define TMPLL_OFS_STATUS 12'h014
`define TMPLL_OFS_NOTIFY 12'h018
`define TMPLL_OFS_IRQ_EN 12'h01C
`define TMPLL_OFS_RAM_INI 12'h020
`define TMPLL_OFS_DIRECT_INC 12'h024
`define TMPLL_OFS_RAM_BASE 12'h400

// Reset values
`define TMPLL_CTRL0_RST 32'h0000_0000
`define TMPLL_CTRL1_RST 32'h0000_0000
`define TMPLL_WORD_RST 32'h0000_0000

// Operation control bits frozen while the PLL is enabled (bits 24-31, 16-20 and 11-15)
`define TMPLL_CTRL1_LOCK_MASK 32'hFF1F_F800

// Profile entry layout
`define TMPLL_ENT_W 20
`define TMPLL_ENT_INC_MSB 19
`define TMPLL_ENT_INC_LSB 16
`define TMPLL_ENT_IRQ_BIT 13

// Notify and status bit positions
`define TMPLL_NTF_TIMEOUT 0
`define TMPLL_NTF_PLAUS 1
`define TMPLL_NTF_PROFILE 18
`define TMPLL_STS_LEVEL 0
`define TMPLL_STS_INIT 1
`define TMPLL_STS_FIRST 2
`define TMPLL_STS_RATE 3
`define TMPLL_STS_LOCKED 26

// Threshold used in direct load mode
`define TMPLL_DIRECT_SCALE 32'h0001_0000

`endif

// [tmpll_pkg.sv]
// Types shared by the micro tick PLL files
`include "tmpll_defs.svh"
package tmpll_pkg;

   // Active trigger slope selection
   typedef enum logic [1:0] {
      TMPLL_EDGE_NONE = 2'b00,
      TMPLL_EDGE_RISE = 2'b01,
      TMPLL_EDGE_FALL = 2'b10,
      TMPLL_EDGE_BOTH = 2'b11
   } tmpll_edge_t;

   // Trigger input configuration word
   typedef struct packed {
      logic tick_source_sel;
      logic trigger_input_on;
      logic state_input_on;
      logic trigger_delay_comp;
      logic state_delay_comp;
      logic trigger_adapt_on;
      logic state_adapt_on;
      logic [8:0] nominal_teeth_count;
      logic [4:0] state_event_count;
      logic filter_unit_sel;
      logic [9:0] ticks_per_event_m1;
   } tmpll_ctrl0_t;

   // Operation mode configuration word
   typedef struct packed {
      tmpll_edge_t active_edge_sel;
      logic [8:0] spare_hi;
      logic [4:0] virtual_tooth_count;
      logic [7:0] spare_mid;
      logic pulse_correct_on;
      logic direct_freq_load;
      logic tick_out_on;
      logic plaus_window_unit;
      logic spare_lo;
      logic missing_tick_fix;
      logic pll_enable;
      logic tick_mode_sel;
   } tmpll_ctrl1_t;

   // Register port request
   typedef struct packed {
      logic [`TMPLL_ADDR_W-1:0] addr;
      logic [`TMPLL_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } tmpll_bus_req_t;

endpackage

// [tmpll_edge_sync.sv]
// Trigger pin synchroniser with accepted level and edge pulses
`timescale 1ns/100ps
module tmpll_edge_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Asynchronous pin
   input wire logic pin_in,
   // Accepted level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
   logic [2:0] fill_q;

   // Three-stage sampling; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         fill_q <= 3'h0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (fill_q != 3'h4)
            fill_q <= fill_q + 3'h1; // No edges until stages hold pin samples
         rise_q <= (fill_q == 3'h4) && (s2_q == s3_q) && s3_q && !lvl_q;
         fall_q <= (fill_q == 3'h4) && (s2_q == s3_q) && !s3_q && lvl_q;
         if (s2_q == s3_q)
            lvl_q <= s3_q;
      end
   end

   assign level = lvl_q;
   assign rise = rise_q;
   assign fall = fall_q;
endmodule

// [tmpll_core.sv]
// Micro tick PLL for a tooth-wheel trigger: registers, profile store, tick generator
`timescale 1ns/100ps
`include "tmpll_defs.svh"
module tmpll_core #(
   parameter int PROF_DEPTH = 128,
   parameter int TS_W = 24,
   parameter int FAST_DIV = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input tmpll_pkg::tmpll_bus_req_t bus_req,
   output logic [31:0] rdata,
   // Trigger pin and time stamp from the time base
   input wire logic trig_in,
   input wire logic [TS_W-1:0] timebase_stamp,
   // Micro ticks toward the time base, interrupt and lock
   output logic microtick_raw,
   output logic microtick_comp,
   output logic profile_irq,
   output logic locked_flag
);
   localparam int IDX_W = $clog2(PROF_DEPTH);
   localparam logic [8:0] DEPTH9 = 9'(PROF_DEPTH);
   localparam logic [7:0] FAST_LAST = 8'(FAST_DIV - 1);

   // Refuse geometries the logic cannot serve
   if (PROF_DEPTH < 4 || PROF_DEPTH > 256 || (1 << IDX_W) != PROF_DEPTH)
   begin : g_bad_depth
      $error("PROF_DEPTH must be a power of two from 4 to 256");
   end
   if (TS_W < 16 || TS_W > 32)
   begin : g_bad_ts
      $error("TS_W must lie between 16 and 32");
   end
   if (FAST_DIV < 1 || FAST_DIV > 256)
   begin : g_bad_div
      $error("FAST_DIV must lie between 1 and 256");
   end

   // Increments of a profile entry; nominal single step when unused
   function automatic logic [3:0] incr_of(input logic [19:0] ent, input logic use_prof);
      logic [3:0] inc;
      inc = ent[`TMPLL_ENT_INC_MSB:`TMPLL_ENT_INC_LSB];
      incr_of = (use_prof && inc != 4'h0) ? inc : 4'h1;
   endfunction

   tmpll_pkg::tmpll_ctrl0_t ctrl0_q;
   tmpll_pkg::tmpll_ctrl1_t ctrl1_q;
   logic [IDX_W-1:0] ptr_q, nxt_ptr, last_idx, init_idx_q, ram_idx;
   logic [TS_W-1:0] thmi_q, tov_q, last_ts_q, elapsed;
   logic [31:0] irq_en_q, notify_q, direct_inc_q, rdata_q, status, notify_set;
   logic [31:0] per_cnt_q, dur_q, acc_q, add_val, thr;
   logic [32:0] acc_sum;
   logic [19:0] ram_q [PROF_DEPTH];
   logic [19:0] nxt_ent;
   logic [14:0] n_ticks, target_q, emitted_q, pending_q, target_new, missing;
   logic [3:0] prev_incr_q, new_incr;
   logic [7:0] fast_cnt_q;
   logic [10:0] full_last;
   logic [9:0] real_teeth;
   logic locked_q, init_busy_q, first_q, have_dur_q, to_done_q, raw_q, comp_q;
   logic lvl, rise_p, fall_p, act_raw, inact_raw, ev, inact, run, out_on;
   logic fast_en, catch, room, gen, auto_end, to_hit, plaus_hit, prof_hit;
   logic ram_hit, ram_wr, apt_wr, wr_ctrl1, wr_notify;

   // Trigger pin conditioning
   tmpll_edge_sync u_sync (
      .clk(clk),
      .resetn(resetn),
      .pin_in(trig_in),
      .level(lvl),
      .rise(rise_p),
      .fall(fall_p)
   );

   // Address decode
   assign ram_hit = bus_req.addr[11:10] == 2'b01 && {1'b0, bus_req.addr[9:2]} < DEPTH9;
   assign ram_idx = bus_req.addr[IDX_W+1:2];
   assign ram_wr = bus_req.wr && ram_hit && !init_busy_q;
   assign apt_wr = bus_req.wr && bus_req.addr == `TMPLL_OFS_PTR;
   assign wr_ctrl1 = bus_req.wr && bus_req.addr == `TMPLL_OFS_CTRL1;
   assign wr_notify = bus_req.wr && bus_req.addr == `TMPLL_OFS_NOTIFY;

   // Run only with PLL and trigger path on and trigger as tick source
   assign run = ctrl1_q.pll_enable && ctrl0_q.trigger_input_on
      && !ctrl0_q.tick_source_sel;
   assign out_on = ctrl1_q.pll_enable && ctrl1_q.tick_out_on;

   // Active and inactive slopes from the edge selection
   always_comb
   begin
      act_raw = 1'b0;
      inact_raw = 1'b0;
      unique case (ctrl1_q.active_edge_sel)
         tmpll_pkg::TMPLL_EDGE_NONE:
         begin
            act_raw = 1'b0;
            inact_raw = 1'b0;
         end
         tmpll_pkg::TMPLL_EDGE_RISE:
         begin
            act_raw = rise_p;
            inact_raw = fall_p;
         end
         tmpll_pkg::TMPLL_EDGE_FALL:
         begin
            act_raw = fall_p;
            inact_raw = rise_p;
         end
         tmpll_pkg::TMPLL_EDGE_BOTH:
         begin
            act_raw = rise_p | fall_p;
            inact_raw = 1'b0;
         end
      endcase
   end
   assign ev = run && act_raw;
   assign inact = run && inact_raw;

   // Last profile index of one full scale: twice the real teeth per half scale, minus one
   always_comb
   begin
      real_teeth = {1'b0, ctrl0_q.nominal_teeth_count} + 10'h001
         - {5'h00, ctrl1_q.virtual_tooth_count};
      full_last = {real_teeth, 1'b0} - 11'h001;
      if (real_teeth == 10'h000 || full_last >= {2'b00, DEPTH9})
         last_idx = IDX_W'(PROF_DEPTH - 1);
      else
         last_idx = full_last[IDX_W-1:0];
   end
   assign nxt_ptr = (ptr_q == last_idx) ? '0 : ptr_q + 1'b1;
   assign nxt_ent = ram_q[nxt_ptr];

   // Tooth to come: nominal entry only, no adaptation values
   assign new_incr = incr_of(nxt_ent, locked_q);
   assign n_ticks = {5'h00, ctrl0_q.ticks_per_event_m1} + 15'h0001;
   assign target_new = n_ticks * {11'h000, new_incr};
   assign auto_end = !ctrl1_q.tick_mode_sel;
   assign missing = (emitted_q < target_q) ? target_q - emitted_q : 15'h0000;

   // Fast catch-up rate as an enable pulse
   assign fast_en = fast_cnt_q == FAST_LAST;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         fast_cnt_q <= 8'h00;
      else if (fast_en)
         fast_cnt_q <= 8'h00;
      else
         fast_cnt_q <= fast_cnt_q + 8'h01;
   end

   // Rate: ticks of the last tooth over its measured length, or software rate
   always_comb
   begin
      if (ctrl1_q.direct_freq_load)
      begin
         add_val = direct_inc_q;
         thr = `TMPLL_DIRECT_SCALE;
      end
      else
      begin
         add_val = {17'h00000, n_ticks} * {28'h0000000, prev_incr_q};
         thr = dur_q;
      end
   end
   assign acc_sum = {1'b0, acc_q} + {1'b0, add_val};
   assign room = !auto_end || emitted_q < target_q;
   assign catch = run && fast_en && pending_q != 15'h0000;
   assign gen = run && have_dur_q && room && !catch && !ev
      && acc_sum >= {1'b0, thr};

   // Phase accumulator spreading the ticks evenly
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         acc_q <= 32'h0000_0000;
      else if (!run || ev)
         acc_q <= 32'h0000_0000;
      else if (gen)
         acc_q <= 32'(acc_sum - {1'b0, thr});
      else if (have_dur_q && room && acc_sum < {1'b0, thr})
         acc_q <= acc_sum[31:0];
   end

   // Tooth period measurement in system clocks
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         per_cnt_q <= 32'h0000_0000;
         dur_q <= 32'h0000_0001;
         prev_incr_q <= 4'h1;
         first_q <= 1'b0;
         have_dur_q <= 1'b0;
         last_ts_q <= '0;
      end
      else if (!run)
      begin
         per_cnt_q <= 32'h0000_0000;
         first_q <= 1'b0;
         have_dur_q <= 1'b0;
      end
      else if (ev)
      begin
         per_cnt_q <= 32'h0000_0001;
         dur_q <= (per_cnt_q == 32'h0000_0000) ? 32'h0000_0001 : per_cnt_q;
         prev_incr_q <= incr_of(ram_q[ptr_q], locked_q);
         first_q <= 1'b1;
         have_dur_q <= first_q;
         last_ts_q <= timebase_stamp;
      end
      else if (per_cnt_q != 32'hFFFF_FFFF)
         per_cnt_q <= per_cnt_q + 32'h0000_0001;
   end

   // Tick budget of the running tooth and catch-up backlog
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         target_q <= 15'h0000;
         emitted_q <= 15'h0000;
         pending_q <= 15'h0000;
      end
      else if (!run)
      begin
         target_q <= 15'h0000;
         emitted_q <= 15'h0000;
         pending_q <= 15'h0000;
      end
      else if (ev)
      begin
         target_q <= target_new;
         emitted_q <= 15'h0000;
         if (auto_end && !ctrl1_q.missing_tick_fix && have_dur_q)
            pending_q <= pending_q + missing - {14'h0000, catch};
         else
            pending_q <= pending_q - {14'h0000, catch};
      end
      else
      begin
         emitted_q <= emitted_q + {14'h0000, gen};
         pending_q <= pending_q - {14'h0000, catch};
      end
   end

   // Tick lines; catch-up on raw only with pulse correction on
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         raw_q <= 1'b0;
         comp_q <= 1'b0;
      end
      else
      begin
         raw_q <= out_on && (gen || (catch && ctrl1_q.pulse_correct_on));
         comp_q <= out_on && (gen || catch);
      end
   end
   assign microtick_raw = raw_q;
   assign microtick_comp = comp_q;

   // Slope timeout and inactive-slope plausibility
   assign elapsed = timebase_stamp - last_ts_q;
   assign to_hit = run && first_q && !to_done_q && !ev && elapsed > tov_q;
   assign plaus_hit = inact && first_q && (ctrl1_q.plaus_window_unit
      ? elapsed < thmi_q
      : {{(TS_W-15){1'b0}}, emitted_q} < thmi_q);
   assign prof_hit = ev && locked_q && nxt_ent[`TMPLL_ENT_IRQ_BIT];

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         to_done_q <= 1'b0;
      else if (ev || !run)
         to_done_q <= 1'b0;
      else if (to_hit)
         to_done_q <= 1'b1;
   end

   // Sticky event flags; a new event wins over a write-one clear
   always_comb
   begin
      notify_set = 32'h0000_0000;
      notify_set[`TMPLL_NTF_TIMEOUT] = to_hit;
      notify_set[`TMPLL_NTF_PLAUS] = plaus_hit;
      notify_set[`TMPLL_NTF_PROFILE] = prof_hit;
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         notify_q <= `TMPLL_WORD_RST;
      else if (wr_notify)
         notify_q <= (notify_q & ~bus_req.wdata) | notify_set;
      else
         notify_q <= notify_q | notify_set;
   end
   assign profile_irq = |(notify_q & irq_en_q);

   // Profile pointer and lock
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ptr_q <= '0;
         locked_q <= 1'b0;
      end
      else
      begin
         if (apt_wr)
            ptr_q <= bus_req.wdata[IDX_W+1:2];
         else if (ev && locked_q)
            ptr_q <= nxt_ptr;
         if (!ctrl1_q.pll_enable)
            locked_q <= 1'b0;
         else if (apt_wr)
            locked_q <= 1'b1;
      end
   end
   assign locked_flag = locked_q;

   // Profile store clearing after reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         init_busy_q <= 1'b1;
         init_idx_q <= '0;
      end
      else if (init_busy_q)
      begin
         init_idx_q <= init_idx_q + 1'b1;
         if (init_idx_q == IDX_W'(PROF_DEPTH - 1))
            init_busy_q <= 1'b0;
      end
   end

   // Profile store entries
   for (genvar gi = 0; gi < PROF_DEPTH; gi++)
   begin : g_ram
      always_ff @(posedge clk)
      begin
         if (init_busy_q && init_idx_q == IDX_W'(gi))
            ram_q[gi] <= 20'h00000;
         else if (ram_wr && ram_idx == IDX_W'(gi))
            ram_q[gi] <= bus_req.wdata[19:0];
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl0_q <= `TMPLL_CTRL0_RST;
         ctrl1_q <= `TMPLL_CTRL1_RST;
         thmi_q <= '0;
         tov_q <= '0;
         irq_en_q <= `TMPLL_WORD_RST;
         direct_inc_q <= `TMPLL_WORD_RST;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == `TMPLL_OFS_CTRL0)
            ctrl0_q <= bus_req.wdata;
         if (wr_ctrl1 && ctrl1_q.pll_enable)
            ctrl1_q <= (ctrl1_q & `TMPLL_CTRL1_LOCK_MASK)
               | (bus_req.wdata & ~`TMPLL_CTRL1_LOCK_MASK);
         else if (wr_ctrl1)
            ctrl1_q <= bus_req.wdata;
         if (bus_req.addr == `TMPLL_OFS_MIN_INACT)
            thmi_q <= bus_req.wdata[TS_W-1:0];
         if (bus_req.addr == `TMPLL_OFS_TIMEOUT)
            tov_q <= bus_req.wdata[TS_W-1:0];
         if (bus_req.addr == `TMPLL_OFS_IRQ_EN)
            irq_en_q <= bus_req.wdata;
         if (bus_req.addr == `TMPLL_OFS_DIRECT_INC)
            direct_inc_q <= bus_req.wdata;
      end
   end

   // Status word
   always_comb
   begin
      status = 32'h0000_0000;
      status[`TMPLL_STS_LEVEL] = lvl;
      status[`TMPLL_STS_INIT] = init_busy_q;
      status[`TMPLL_STS_FIRST] = first_q;
      status[`TMPLL_STS_RATE] = have_dur_q;
      status[`TMPLL_STS_LOCKED] = locked_q;
   end

   // Read data, valid in the cycle after the read strobe only
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata_q <= 32'h0000_0000;
      else if (!bus_req.rd)
         rdata_q <= 32'h0000_0000;
      else if (ram_hit)
         rdata_q <= {12'h000, ram_q[ram_idx]};
      else
      begin
         unique case (bus_req.addr)
            `TMPLL_OFS_CTRL0: rdata_q <= ctrl0_q;
            `TMPLL_OFS_CTRL1: rdata_q <= ctrl1_q;
            `TMPLL_OFS_PTR: rdata_q <= {{(30-IDX_W){1'b0}}, ptr_q, 2'b00};
            `TMPLL_OFS_MIN_INACT: rdata_q <= 32'(thmi_q);
            `TMPLL_OFS_TIMEOUT: rdata_q <= 32'(tov_q);
            `TMPLL_OFS_STATUS: rdata_q <= status;
            `TMPLL_OFS_NOTIFY: rdata_q <= notify_q;
            `TMPLL_OFS_IRQ_EN: rdata_q <= irq_en_q;
            `TMPLL_OFS_RAM_INI: rdata_q <= {31'h0000_0000, init_busy_q};
            `TMPLL_OFS_DIRECT_INC: rdata_q <= direct_inc_q;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign rdata = rdata_q;
endmodule

// [tmpll_core_chk.sv]
// Port-level assertions for the micro tick PLL core
`timescale 1ns/100ps
`include "tmpll_defs.svh"
module tmpll_core_chk #(
   parameter int PROF_DEPTH = 128,
   parameter int TS_W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input tmpll_pkg::tmpll_bus_req_t bus_req,
   input wire logic [31:0] rdata,
   // Trigger pin and time stamp
   input wire logic trig_in,
   input wire logic [TS_W-1:0] timebase_stamp,
   // Ticks, interrupt and lock
   input wire logic microtick_raw,
   input wire logic microtick_comp,
   input wire logic profile_irq,
   input wire logic locked_flag
);
   logic [31:0] c0_q;
   logic [31:0] c1_q;
   logic [31:0] ie_q;
   logic [10:0] cnt_q;
   logic go;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Shadow of control words and interrupt enable
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         c0_q <= 32'h0;
         c1_q <= 32'h0;
         ie_q <= 32'h0;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == `TMPLL_OFS_CTRL0)
            c0_q <= bus_req.wdata;
         if (bus_req.addr == `TMPLL_OFS_CTRL1)
            c1_q <= c1_q[1] ? ((c1_q & `TMPLL_CTRL1_LOCK_MASK) |
               (bus_req.wdata & ~`TMPLL_CTRL1_LOCK_MASK)) : bus_req.wdata;
         if (bus_req.addr == `TMPLL_OFS_IRQ_EN)
            ie_q <= bus_req.wdata;
      end
   end

   // Cycles since reset release, saturating
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt_q <= 11'h0;
      else
         cnt_q <= cnt_q + {10'h0, cnt_q != 11'h7FF};
   end

   // Tick path fully enabled
   assign go = c1_q[1] & c1_q[5] & c0_q[30] & ~c0_q[31];

   AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
      else $error("read data not zero outside read answer");
   AST_CTRL0_RB: assert property (bus_req.rd && bus_req.addr == `TMPLL_OFS_CTRL0
      |=> rdata == c0_q) else $error("trigger config readback wrong");
   AST_CTRL1_RB: assert property (bus_req.rd && bus_req.addr == `TMPLL_OFS_CTRL1
      |=> rdata == c1_q) else $error("mode config readback wrong");
   AST_INI_BUSY: assert property (bus_req.rd && bus_req.addr == `TMPLL_OFS_RAM_INI
      && cnt_q >= 11'h1 && cnt_q < PROF_DEPTH - 1 |=> rdata == 32'h1)
      else $error("profile init not shown busy");
   AST_INI_DONE: assert property (bus_req.rd && bus_req.addr == `TMPLL_OFS_RAM_INI
      && cnt_q > PROF_DEPTH + 1 |=> rdata == 32'h0) else $error("profile init not done");
   AST_GATE: assert property (microtick_raw || microtick_comp |-> go || $past(go))
      else $error("tick while tick path disabled");
   AST_RAW_COMP: assert property (microtick_raw |-> microtick_comp)
      else $error("raw tick without compensated tick");
   AST_LOCK_ROSE: assert property ($rose(locked_flag) |->
      $past(bus_req.wr && bus_req.addr == `TMPLL_OFS_PTR)) else $error("lock without pointer write");
   AST_IRQ_EN: assert property (profile_irq |-> (ie_q & 32'h0004_0003) != 32'h0)
      else $error("interrupt while not enabled");
endmodule

bind tmpll_core tmpll_core_chk #(.PROF_DEPTH(PROF_DEPTH), .TS_W(TS_W)) tmpll_core_chk_inst (
   .clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata), .trig_in(trig_in),
   .timebase_stamp(timebase_stamp), .microtick_raw(microtick_raw),
   .microtick_comp(microtick_comp), .profile_irq(profile_irq), .locked_flag(locked_flag));

// [tmpll_wheel.sv]
// Tooth wheel trigger and time base stamp model
`timescale 1ns/100ps
module tmpll_wheel #(
   parameter int HALF = 100
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Trigger pin and time stamp
   output logic trig_in,
   output logic [23:0] stamp
);
   int cnt;

   // Square wave, falling edge starts each tooth
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt <= 0;
         trig_in <= 1'b1;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         trig_in <= ~trig_in;
      end
      else
         cnt <= cnt + 1;
   end

   // Time stamp, one count per clock
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         stamp <= 24'h0;
      else
         stamp <= stamp + 24'h1;
   end
endmodule

// [tb_tmpll_core.sv]
// Self-checking bench for the micro tick PLL core
`timescale 1ns/100ps
`include "tmpll_defs.svh"
module tb_tmpll_core;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   tmpll_pkg::tmpll_bus_req_t bus_req = '0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic trig_in;
   logic [23:0] stamp;
   logic microtick_raw;
   logic microtick_comp;
   logic profile_irq;
   logic locked_flag;
   logic [15:0] lfsr_v = 16'h001F;
   logic [31:0] mdl [int];
   logic [11:0] regs [9] = '{`TMPLL_OFS_CTRL0, `TMPLL_OFS_CTRL1, `TMPLL_OFS_MIN_INACT,
      `TMPLL_OFS_TIMEOUT, `TMPLL_OFS_IRQ_EN, `TMPLL_OFS_DIRECT_INC, 12'h400, 12'h404, 12'h408};
   int err_count = 0;
   int check_count = 0;
   int ticks = 0;
   int raw = 0;
   int n;

   tmpll_core tmpll_core_inst (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
      .trig_in(trig_in), .timebase_stamp(stamp), .microtick_raw(microtick_raw),
      .microtick_comp(microtick_comp), .profile_irq(profile_irq), .locked_flag(locked_flag));
   tmpll_wheel tmpll_wheel_inst (.clk(clk), .resetn(resetn), .trig_in(trig_in), .stamp(stamp));

   // Clock and tick counters, sampled mid-cycle
   always #50 clk = ~clk;
   always @(negedge clk)
      if (microtick_comp === 1'b1) ticks++;
   always @(negedge clk)
      if (microtick_raw === 1'b1) raw++;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One write cycle, model follows protection
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      if (a == `TMPLL_OFS_CTRL1 && mdl[a][1])
         mdl[a] = (mdl[a] & `TMPLL_CTRL1_LOCK_MASK) | (d & ~`TMPLL_CTRL1_LOCK_MASK);
      else if (mdl.exists(a))
         mdl[a] = (a >= `TMPLL_OFS_RAM_BASE) ? (d & 32'h000F_FFFF) : d;
   endtask

   // One read cycle, data taken in the answer cycle
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [11:0] a);
      logic [31:0] d;
      rd_reg(a, d);
      chk("register", mdl.exists(a) ? mdl[a] : 32'h0, d);
   endtask

   // Compensated ticks within one tooth period
   task automatic count_period(output int cnt);
      int t0;
      @(negedge trig_in);
      t0 = ticks;
      @(negedge trig_in);
      cnt = ticks - t0;
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      #2000000;
      err_count++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      foreach (regs[i]) mdl[regs[i]] = 32'h0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd_reg(`TMPLL_OFS_RAM_INI, v);
      chk("ram_ini busy", 32'h1, v);
      for (int i = 0; i < 400 && v !== 32'h0; i++) rd_reg(`TMPLL_OFS_RAM_INI, v);
      chk("ram_ini done", 32'h0, v);
      foreach (regs[i]) rd_chk(regs[i]);
      for (int i = 0; i < 4; i++)
      begin
         lfsr_v = lfsr(lfsr_v);
         wr_reg(12'h030 + 12'(4 * i), {lfsr_v, ~lfsr_v});
         rd_chk(12'h030 + 12'(4 * i));
         wr_reg(`TMPLL_OFS_DIRECT_INC, {~lfsr_v, lfsr_v});
         rd_chk(`TMPLL_OFS_DIRECT_INC);
         wr_reg(`TMPLL_OFS_MIN_INACT, {16'h0, lfsr_v});
         rd_chk(`TMPLL_OFS_MIN_INACT);
      end
      wr_reg(`TMPLL_OFS_MIN_INACT, 32'h0);
      wr_reg(`TMPLL_OFS_TIMEOUT, 32'h780);
      wr_reg(12'h400, 32'h10000);
      wr_reg(12'h404, 32'h12000);
      wr_reg(12'h408, 32'hFFF10000);
      for (int i = 3; i < 9; i++) rd_chk(regs[i]);
      wr_reg(`TMPLL_OFS_IRQ_EN, 32'h00040000);
      wr_reg(`TMPLL_OFS_CTRL0, 32'h403B0009);
      wr_reg(`TMPLL_OFS_CTRL1, 32'h80020000);
      wr_reg(`TMPLL_OFS_CTRL1, 32'h80020012);
      wr_reg(`TMPLL_OFS_CTRL1, 32'h00000012);
      rd_chk(`TMPLL_OFS_CTRL0);
      rd_chk(`TMPLL_OFS_CTRL1);
      for (int i = 0; i < 3; i++)
      begin
         count_period(n);
         chk("ticks while output off", 32'h0, 32'(n));
      end
      chk("raw ticks while off", 32'h0, 32'(raw));
      wr_reg(`TMPLL_OFS_CTRL1, 32'h80020032);
      repeat (3) count_period(n);
      for (int i = 0; i < 3; i++)
      begin
         count_period(n);
         chk("ticks per tooth", 32'd10, 32'(n));
      end
      wr_reg(`TMPLL_OFS_PTR, 32'h0);
      @(posedge clk);
      #1 chk("locked", 32'h1, {31'h0, locked_flag});
      for (int i = 0; i < 1000 && profile_irq !== 1'b1; i++) @(posedge clk);
      chk("profile irq", 32'h1, {31'h0, profile_irq});
      rd_reg(`TMPLL_OFS_NOTIFY, v);
      chk("notify", 32'h00040000, v);
      wr_reg(`TMPLL_OFS_NOTIFY, 32'h00040000);
      @(posedge clk);
      #1 chk("irq cleared", 32'h0, {31'h0, profile_irq});
      count_period(n);
      chk("ticks when locked", 32'd10, 32'(n));
      chk("raw ticks seen", 32'h1, {31'h0, raw > 0});
      wr_reg(`TMPLL_OFS_DIRECT_INC, 32'h0);
      wr_reg(`TMPLL_OFS_CTRL1, 32'h80020072);
      count_period(n);
      v = 32'(raw);
      count_period(n);
      chk("direct load comp ticks", 32'd10, 32'(n));
      chk("direct load raw ticks", v, 32'(raw));
      print_verdict();
   end
endmodule
